// [hw/uart1_baud.sv]
`timescale 1ns/10ps
`include "uart1_params.svh"
module uart1_baud
  import uart1_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Rate selection
  input wire port_mode_e mode,
  input wire logic baud_double,
  input wire logic timer3_ovf,
  // Bit rate enable
  output logic baud_tick
);
  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;
  logic [6:0] divisor;
  logic advance;

  // ========================================
  // Divider
  always_comb begin
    unique case (mode)
      MODE_SYNC: divisor = `DIV_SYNC;
      MODE_ASYNC11: divisor = baud_double ? `DIV_M2_DBL : `DIV_M2;
      default: divisor = `DIV_TIMER;
    endcase
    advance = (mode == MODE_ASYNC10 || mode == MODE_ASYNC11_T) ? timer3_ovf : 1'b1;
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (advance) begin
      if (cnt_ff == 7'h00 || cnt_ff >= divisor) begin
        nxt_cnt = divisor - 7'h01;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 7'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 7'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign baud_tick = tick_ff;
endmodule // uart1_baud

// [hw/uart1_ctrl.sv]
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/10ps
`include "uart1_params.svh"
// How it works
// [R1] Top two port 1 control bits select mode; modes 1 and 3 use timer 3 overflow/16.
// [R2] Timer 3 control bit picks whether bit 7 reaches mode bit or frame error.
// [R3] Port 1 baud doubling applies only in mode 2.
// [R4] Frame error view of bit 7: set by hardware, cleared only by software.
// [R5] Multiprocessor enable has no effect in mode 0.
// [R6] Mode 1 with multiprocessor: accept only stop bit 1 and address match.
// [R7] Mode 1 without multiprocessor: accept every frame.
// [R8] Modes 2, 3 with multiprocessor: accept only ninth bit 1 and address match.
// [R9] Modes 2, 3 without multiprocessor: accept every frame.
// [R10] Receive enable low blocks reception; high enables modes 1 to 3.
// [R11] Mode 0 reception starts while receive enable is 1 and receive flag 0.
// [R12] Transmit ninth bit is sent in modes 2, 3, ignored in 0, 1.
// [R13] Modes 2, 3 store the received ninth bit.
// [R14] Mode 1 stores the stop bit, subject to filtering; mode 0 stores nothing.
// [R15] Transmit done flag set when a frame has been sent.
// [R16] Receive done flag set after an accepted frame.
// [R17] Either done flag requests the port 1 interrupt while enabled.
// [R18] Software clears both done flags; hardware never does.
// [R19] Port 0 doubling in mode 2, or modes 1, 3 with timer 1 source.
// [R20] Port 0 view bit picks mode bit or frame error at bit 7.
// [R21] Mode bit and frame error are separate storage behind one view.
module uart1_ctrl
  import uart1_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Port 1 shifter events
  input wire logic port1_tx_sent,
  input wire logic port1_rx_frame_done,
  input wire logic port1_rx_bit9,
  input wire logic port1_rx_addr_match,
  input wire logic port1_frame_err_event,
  input wire logic timer3_ovf,
  input wire logic port1_irq_enable,
  // Port 1 control to shifter
  output port_mode_e port1_mode,
  output logic port1_rx_go,
  output logic port1_tx_ninth_bit,
  output logic port1_baud_tick,
  output logic port1_irq,
  // Port 0 side
  input wire logic port0_frame_err_event,
  input wire logic port0_timer1_source,
  output logic port0_mode_hi,
  output logic port0_baud_x2
);
  // ========================================
  // Register state
  logic mode_hi1_ff, mode_lo1_ff, mp1_ff, ren1_ff, tb81_ff, rb81_ff, ti1_ff, ri1_ff, fe1_ff;
  logic nxt_mode_hi1, nxt_mode_lo1, nxt_mp1, nxt_ren1, nxt_tb81, nxt_rb81, nxt_ti1, nxt_ri1, nxt_fe1;
  logic dbl1_ff, view1_ff, nxt_dbl1, nxt_view1;
  logic dbl0_ff, view0_ff, nxt_dbl0, nxt_view0;
  logic mode_hi0_ff, mode_lo0_ff, fe0_ff, nxt_mode_hi0, nxt_mode_lo0, nxt_fe0;
  logic [`PWR_LOW_MSB:0] pwr_low_ff;
  logic [`PWR_LOW_MSB:0] nxt_pwr_low;
  // Bus state
  logic wait_ff, nxt_wait;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  // Output state
  logic rx_go_ff, tx9_ff, irq_ff, x2_0_ff;
  logic nxt_rx_go, nxt_tx9, nxt_irq, nxt_x2_0;

  logic [7:0] idx;
  logic aligned;
  logic wr_take;
  logic wr_p1, wr_p0, wr_pwr, wr_t3;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  port_mode_e mode1;
  logic rx_accept, rx_store;

  assign mode1 = port_mode_e'({mode_hi1_ff, mode_lo1_ff}); // R1

  // ========================================
  // Receive filter
  uart1_rx_filter u_filter (
    .mode(mode1),
    .multiproc(mp1_ff), // R5
    .rx_enable(ren1_ff), // R10
    .frame_done(port1_rx_frame_done),
    .bit9(port1_rx_bit9),
    .addr_match(port1_rx_addr_match),
    .accept(rx_accept), // R6 R7 R8 R9
    .store_bit9(rx_store)
  );

  // ========================================
  // Baud rate
  uart1_baud u_baud (
    .mclk(mclk),
    .rst_n(rst_n),
    .mode(mode1), // R1
    .baud_double(dbl1_ff), // R3
    .timer3_ovf(timer3_ovf),
    .baud_tick(port1_baud_tick)
  );

  // ========================================
  // Address decode
  always_comb begin
    idx = avs_address[9:`ADDR_LSB];
    aligned = (avs_address[`ADDR_LSB-1:0] == 2'h0);
    wr_take = avs_write & !wait_ff;
    wr_p1 = wr_take & aligned & (idx == `IDX_P1_CTL);
    wr_p0 = wr_take & aligned & (idx == `IDX_P0_CTL);
    wr_pwr = wr_take & aligned & (idx == `IDX_PWR_CTL);
    wr_t3 = wr_take & aligned & (idx == `IDX_T3_CTL);
    wbyte = avs_writedata[7:0];
  end

  // ========================================
  // Read mux
  always_comb begin
    rbyte = 8'h00;
    if (aligned) begin
      unique case (idx)
        `IDX_P1_CTL: rbyte = {view1_ff ? fe1_ff : mode_hi1_ff, mode_lo1_ff, mp1_ff, ren1_ff, // R2 R4
                              tb81_ff, rb81_ff, ti1_ff, ri1_ff};
        `IDX_P0_CTL: rbyte = {view0_ff ? fe0_ff : mode_hi0_ff, mode_lo0_ff, 6'h00}; // R20
        `IDX_PWR_CTL: rbyte = {dbl0_ff, view0_ff, 1'b0, pwr_low_ff};
        `IDX_T3_CTL: rbyte = {dbl1_ff, view1_ff, 6'h00};
        default: rbyte = 8'h00;
      endcase
    end
  end

  // ========================================
  // Bus handshake, one wait cycle then answer
  always_comb begin
    nxt_wait = 1'b1;
    nxt_rdata = rdata_ff;
    if ((avs_read | avs_write) && wait_ff) begin
      nxt_wait = 1'b0;
      nxt_rdata = {24'h000000, rbyte};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  // ========================================
  // Port 1 control register
  always_comb begin
    nxt_mode_hi1 = mode_hi1_ff;
    nxt_fe1 = fe1_ff;
    nxt_mode_lo1 = mode_lo1_ff;
    nxt_mp1 = mp1_ff;
    nxt_ren1 = ren1_ff;
    nxt_tb81 = tb81_ff;
    nxt_rb81 = rb81_ff;
    nxt_ti1 = ti1_ff;
    nxt_ri1 = ri1_ff;
    if (wr_p1) begin
      if (view1_ff) begin
        nxt_fe1 = wbyte[`BIT_VIEW7]; // R4 R21
      end else begin
        nxt_mode_hi1 = wbyte[`BIT_VIEW7]; // R21
      end
      nxt_mode_lo1 = wbyte[`BIT_MODE_LO];
      nxt_mp1 = wbyte[`BIT_MP];
      nxt_ren1 = wbyte[`BIT_REN];
      nxt_tb81 = wbyte[`BIT_TB8];
      nxt_rb81 = wbyte[`BIT_RB8];
      nxt_ti1 = wbyte[`BIT_TI]; // R18
      nxt_ri1 = wbyte[`BIT_RI]; // R18
    end
    // Hardware events win over a clearing write
    if (port1_frame_err_event) begin
      nxt_fe1 = 1'b1; // R4
    end
    if (rx_store) begin
      nxt_rb81 = port1_rx_bit9; // R13 R14
    end
    if (port1_tx_sent) begin
      nxt_ti1 = 1'b1; // R15
    end
    if (rx_accept) begin
      nxt_ri1 = 1'b1; // R16
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_hi1_ff <= 1'b0;
      fe1_ff <= 1'b0;
      mode_lo1_ff <= 1'b0;
      mp1_ff <= 1'b0;
      ren1_ff <= 1'b0;
      tb81_ff <= 1'b0;
      rb81_ff <= 1'b0;
      ti1_ff <= 1'b0;
      ri1_ff <= 1'b0;
    end else begin
      mode_hi1_ff <= nxt_mode_hi1;
      fe1_ff <= nxt_fe1;
      mode_lo1_ff <= nxt_mode_lo1;
      mp1_ff <= nxt_mp1;
      ren1_ff <= nxt_ren1;
      tb81_ff <= nxt_tb81;
      rb81_ff <= nxt_rb81;
      ti1_ff <= nxt_ti1;
      ri1_ff <= nxt_ri1;
    end
  end

  // ========================================
  // Power, timer 3 and port 0 control bits
  always_comb begin
    nxt_dbl0 = dbl0_ff;
    nxt_view0 = view0_ff;
    nxt_pwr_low = pwr_low_ff;
    nxt_dbl1 = dbl1_ff;
    nxt_view1 = view1_ff;
    nxt_mode_hi0 = mode_hi0_ff;
    nxt_mode_lo0 = mode_lo0_ff;
    nxt_fe0 = fe0_ff;
    if (wr_pwr) begin
      nxt_dbl0 = wbyte[`BIT_BAUD_DBL];
      nxt_view0 = wbyte[`BIT_FE_VIEW];
      nxt_pwr_low = wbyte[`PWR_LOW_MSB:0];
    end
    if (wr_t3) begin
      nxt_dbl1 = wbyte[`BIT_BAUD_DBL];
      nxt_view1 = wbyte[`BIT_FE_VIEW]; // R2
    end
    if (wr_p0) begin
      if (view0_ff) begin
        nxt_fe0 = wbyte[`BIT_VIEW7]; // R20 R21
      end else begin
        nxt_mode_hi0 = wbyte[`BIT_VIEW7]; // R20
      end
      nxt_mode_lo0 = wbyte[`BIT_MODE_LO];
    end
    if (port0_frame_err_event) begin
      nxt_fe0 = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dbl0_ff <= 1'b0;
      view0_ff <= 1'b0;
      pwr_low_ff <= '0;
      dbl1_ff <= 1'b0;
      view1_ff <= 1'b0;
      mode_hi0_ff <= 1'b0;
      mode_lo0_ff <= 1'b0;
      fe0_ff <= 1'b0;
    end else begin
      dbl0_ff <= nxt_dbl0;
      view0_ff <= nxt_view0;
      pwr_low_ff <= nxt_pwr_low;
      dbl1_ff <= nxt_dbl1;
      view1_ff <= nxt_view1;
      mode_hi0_ff <= nxt_mode_hi0;
      mode_lo0_ff <= nxt_mode_lo0;
      fe0_ff <= nxt_fe0;
    end
  end

  // ========================================
  // Registered control outputs
  always_comb begin
    if (mode1 == MODE_SYNC) begin
      nxt_rx_go = ren1_ff & !ri1_ff; // R11
    end else begin
      nxt_rx_go = ren1_ff; // R10
    end
    nxt_tx9 = tb81_ff & mode_hi1_ff; // R12
    nxt_irq = port1_irq_enable & (ti1_ff | ri1_ff); // R17
    unique case ({mode_hi0_ff, mode_lo0_ff})
      2'h2: nxt_x2_0 = dbl0_ff; // R19
      2'h1, 2'h3: nxt_x2_0 = dbl0_ff & port0_timer1_source; // R19
      default: nxt_x2_0 = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_go_ff <= 1'b0;
      tx9_ff <= 1'b0;
      irq_ff <= 1'b0;
      x2_0_ff <= 1'b0;
    end else begin
      rx_go_ff <= nxt_rx_go;
      tx9_ff <= nxt_tx9;
      irq_ff <= nxt_irq;
      x2_0_ff <= nxt_x2_0;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign port1_mode = mode1;
  assign port1_rx_go = rx_go_ff;
  assign port1_tx_ninth_bit = tx9_ff;
  assign port1_irq = irq_ff;
  assign port0_mode_hi = mode_hi0_ff;
  assign port0_baud_x2 = x2_0_ff;

  // ========================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  AST_BUS_ANSWER: assert property (s_req |=> s_ack)
    else $error("bus request not answered in one cycle");
  AST_TI_SET: assert property (port1_tx_sent |=> ti1_ff) // R15
    else $error("transmit done flag not set");
  AST_RI_SET: assert property (rx_accept |=> ri1_ff ##1 (ri1_ff || $past(wr_p1))) // R16
    else $error("receive done flag not set");
  AST_FLAGS_HELD: assert property ((ti1_ff && ri1_ff && !wr_p1) |=> (ti1_ff && ri1_ff)) // R18
    else $error("done flag cleared by hardware");
  AST_FE_STICKY: assert property ((fe1_ff && !wr_p1) |=> fe1_ff) // R4
    else $error("frame error cleared without write");
  AST_MP_REJECT: assert property ((port1_rx_frame_done && mp1_ff && mode1 != MODE_SYNC && !port1_rx_bit9 // R6
                                   && !ri1_ff && !wr_p1) |=> !ri1_ff)
    else $error("filtered frame raised receive flag");
  AST_MODE0_ACCEPT: assert property ((mode1 == MODE_SYNC && port1_rx_frame_done && ren1_ff) |=> ri1_ff) // R5
    else $error("mode 0 frame not accepted");
  AST_REN_OFF: assert property ((port1_rx_frame_done && !ren1_ff && !ri1_ff && !wr_p1) |=> !ri1_ff) // R10
    else $error("frame accepted while reception disabled");
  AST_IRQ: assert property ((port1_irq_enable && (ti1_ff || ri1_ff)) |=> port1_irq) // R17
    else $error("interrupt not requested");
  AST_TX9_MODE01: assert property ((!mode_hi1_ff && !wr_p1) |=> ##1 !port1_tx_ninth_bit) // R12
    else $error("ninth bit sent in mode 0 or 1");
  AST_RB8_STORE: assert property (rx_store |=> rb81_ff == $past(port1_rx_bit9)) // R13
    else $error("received ninth bit not stored");
  AST_VIEW_SEPARATE: assert property ((wr_p1 && view1_ff) |=> $stable(mode_hi1_ff)) // R21
    else $error("frame error write changed mode bit");
  AST_RX_GO_M0: assert property ((mode1 == MODE_SYNC && ren1_ff && ri1_ff) |=> !port1_rx_go) // R11
    else $error("mode 0 reception started with flag set");
endmodule // uart1_ctrl

// [hw/uart1_params.svh]
`ifndef UART1_PARAMS_SVH
`define UART1_PARAMS_SVH
// ========================================
// Register indices, byte address is index times four
`define IDX_PWR_CTL 8'h87
`define IDX_P0_CTL 8'h98
`define IDX_T3_CTL 8'hc4
`define IDX_P1_CTL 8'hf8
`define ADDR_LSB 2
// ========================================
// Serial control register fields
`define BIT_VIEW7 7
`define BIT_MODE_LO 6
`define BIT_MP 5
`define BIT_REN 4
`define BIT_TB8 3
`define BIT_RB8 2
`define BIT_TI 1
`define BIT_RI 0
// ========================================
// Power and timer 3 control fields
`define BIT_BAUD_DBL 7
`define BIT_FE_VIEW 6
`define PWR_LOW_MSB 4
`define RESET_BYTE 8'h00
// ========================================
// Baud dividers
`define DIV_SYNC 7'h0c
`define DIV_M2 7'h40
`define DIV_M2_DBL 7'h20
`define DIV_TIMER 7'h10
`endif

// [hw/uart1_pkg.sv]
package uart1_pkg;
  typedef enum logic [1:0] {
    MODE_SYNC = 2'h0,
    MODE_ASYNC10 = 2'h1,
    MODE_ASYNC11 = 2'h2,
    MODE_ASYNC11_T = 2'h3
  } port_mode_e;
endpackage

// [hw/uart1_rx_filter.sv]
`timescale 1ns/10ps
module uart1_rx_filter
  import uart1_pkg::*;
(
  // Control state
  input wire port_mode_e mode,
  input wire logic multiproc,
  input wire logic rx_enable,
  // Frame from the shifter
  input wire logic frame_done,
  input wire logic bit9,
  input wire logic addr_match,
  // Verdict
  output logic accept,
  output logic store_bit9
);
  logic gate_ok;

  always_comb begin
    // Address and stop or ninth bit check only outside mode 0
    if (mode == MODE_SYNC || !multiproc) begin
      gate_ok = 1'b1;
    end else begin
      gate_ok = bit9 & addr_match;
    end
    accept = frame_done & rx_enable & gate_ok;
    store_bit9 = accept & (mode != MODE_SYNC);
  end
endmodule // uart1_rx_filter

// [test/uart1_line_model.sv]
`timescale 1ns/10ps
// ========================================
// Far-side serial device, seen as shifter events
module uart1_line_model (
  // Clock
  input wire logic mclk,
  // Events
  output logic tx_sent,
  output logic frame_done,
  output logic bit9,
  output logic addr_match,
  output logic fe1_event,
  output logic fe0_event,
  output logic timer3_ovf
);
  int tdiv = 0;
  initial begin
    {tx_sent, frame_done, bit9, addr_match, fe1_event, fe0_event, timer3_ovf} = '0;
  end
  // Overflow pulse every fourth clock
  always @(posedge mclk) begin
    tdiv <= (tdiv + 1) % 4;
    timer3_ovf <= (tdiv == 3);
  end
  // One cycle of events, then qualifiers turn to their inverse
  task automatic burst(input logic fd, b, m, tx, f1, f0);
    frame_done <= fd;
    bit9 <= b;
    addr_match <= m;
    tx_sent <= tx;
    fe1_event <= f1;
    fe0_event <= f0;
    @(posedge mclk);
    {frame_done, tx_sent, fe1_event, fe0_event} <= '0;
    bit9 <= ~b;
    addr_match <= ~m;
    @(posedge mclk);
  endtask
endmodule // uart1_line_model

// [test/uart_port1_control_status_tb.sv]
`timescale 1ns/10ps
module uart_port1_control_status_tb;
  import uart1_pkg::*;
  localparam logic [9:0] A_PWR = 10'h21c, A_P0 = 10'h260, A_T3 = 10'h310, A_P1 = 10'h3e0;
  logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, irq_en, t1_src;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed, r;
  logic tx_sent, frame_done, bit9, addr_match, fe1_event, fe0_event, timer3_ovf;
  logic rx_go, tx9, tick, irq, p0_hi, p0_x2, ok, view, fe1;
  logic [7:0] s1, q;
  port_mode_e p1_mode;
  int mismatches, checks, n;
  logic [9:0] addrs [6] = '{A_PWR, A_P0, A_T3, A_P1, 10'h004, 10'h3e1};

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  uart1_ctrl dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port1_tx_sent(tx_sent), .port1_rx_frame_done(frame_done),
    .port1_rx_bit9(bit9), .port1_rx_addr_match(addr_match), .port1_frame_err_event(fe1_event),
    .timer3_ovf(timer3_ovf), .port1_irq_enable(irq_en), .port1_mode(p1_mode), .port1_rx_go(rx_go),
    .port1_tx_ninth_bit(tx9), .port1_baud_tick(tick), .port1_irq(irq),
    .port0_frame_err_event(fe0_event), .port0_timer1_source(t1_src), .port0_mode_hi(p0_hi),
    .port0_baud_x2(p0_x2));

  uart1_line_model ln (.mclk(mclk), .tx_sent(tx_sent), .frame_done(frame_done), .bit9(bit9),
    .addr_match(addr_match), .fe1_event(fe1_event), .fe0_event(fe0_event), .timer3_ovf(timer3_ovf));

  // ========================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Avalon-MM access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] qd);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= ~w;
    avs_write <= w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge mclk);
      k++;
    end
    if (avs_waitrequest !== 1'b0)
      mismatches++;
    qd = avs_readdata[7:0];
    if (!w)
      chk({7'h00, avs_readdata[31:8] != 24'h000000}, 8'h00);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  // Port 1 control write, mirrored into the model
  task automatic w1(input logic [7:0] d);
    acc(1'b1, A_P1, d, q);
    if (view)
      fe1 = d[7];
    else
      s1[7] = d[7];
    s1[6:0] = d[6:0];
  endtask

  task automatic gap(output int g);
    g = 0;
    while (tick !== 1'b1 && g < 300) begin
      @(posedge mclk);
      g++;
    end
    g = 0;
    do begin
      @(posedge mclk);
      g++;
    end while (tick !== 1'b1 && g < 300);
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    conclude();
  end

  // ========================================
  // Tests
  initial begin
    {avs_read, avs_write, irq_en, t1_src, view, fe1, rst_n} = '0;
    avs_address = 10'h000;
    avs_writedata = 32'h00000000;
    s1 = 8'h00;
    seed = 32'h00006277;
    mismatches = 0;
    checks = 0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    foreach (addrs[i]) begin
      acc(1'b0, addrs[i], 8'h00, q);
      chk(q, 8'h00);
    end
    $display("test reset and unmapped done");
    for (int i = 0; i < 64; i++) begin
      r = xs();
      view = r[10];
      acc(1'b1, A_T3, {r[11], r[10], 6'h00}, q);
      irq_en <= r[7];
      w1({r[1:0], r[2], r[5], r[6], 3'h0});
      ln.burst(r[12], r[3], r[4], r[8], r[9], 1'b0);
      ok = r[12] && s1[4] && (s1[7:6] == 2'h0 || !s1[5] || (r[3] && r[4]));
      if (ok)
        s1[0] = 1'b1;
      if (ok && s1[7:6] != 2'h0)
        s1[2] = r[3];
      if (r[8])
        s1[1] = 1'b1;
      if (r[9])
        fe1 = 1'b1;
      acc(1'b0, A_P1, 8'h00, q);
      chk(q, {view ? fe1 : s1[7], s1[6:0]});
      chk({6'h00, p1_mode}, {6'h00, s1[7:6]});
      chk({7'h00, tx9}, {7'h00, s1[7] & s1[3]});
      chk({7'h00, irq}, {7'h00, r[7] & (s1[0] | s1[1])});
      chk({7'h00, rx_go}, {7'h00, s1[4] & (s1[7:6] != 2'h0 | !s1[0])});
    end
    $display("test receive filter and flags done");
    view = 1'b0;
    acc(1'b1, A_T3, 8'h00, q);
    for (int j = 0; j < 16; j++) begin
      acc(1'b1, A_T3, {j[2], 7'h00}, q);
      w1({j[1:0], j[3], 5'h00});
      gap(n);
      gap(n);
      chk(n[7:0], j[1:0] == 2'h0 ? 8'h0c : (j[1:0] == 2'h2 ? (j[2] ? 8'h20 : 8'h40) : 8'h40));
    end
    $display("test bit rate done");
    for (int j = 0; j < 16; j++) begin
      t1_src <= j[2];
      acc(1'b1, A_P0, {j[1:0], 6'h00}, q);
      acc(1'b1, A_PWR, {j[3], 7'h3f}, q);
      acc(1'b0, A_PWR, 8'h00, q);
      chk(q, {j[3], 7'h1f});
      chk({6'h00, p0_x2, p0_hi}, {6'h00, j[3] & (j[1:0] == 2'h2 | (j[0] & j[2])), j[1]});
    end
    acc(1'b1, A_PWR, 8'h40, q);
    ln.burst(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    acc(1'b0, A_P0, 8'h00, q);
    chk(q, 8'hc0);
    chk({7'h00, p0_hi}, 8'h01);
    acc(1'b1, A_P0, 8'h40, q);
    acc(1'b0, A_P0, 8'h00, q);
    chk(q, 8'h40);
    chk({7'h00, p0_hi}, 8'h01);
    $display("test port 0 done");
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    acc(1'b0, A_P1, 8'h00, q);
    chk(q, 8'h00);
    $display("test second reset done");
    conclude();
  end
endmodule // uart_port1_control_status_tb
